// [src/reh_pkg.sv]
// shared constants for the level-one ram error handler
// assumes single core clock, synchronous active-high reset
package reh_pkg;
  // source rams feeding the handler
  typedef enum logic [2:0] {
    SRC_DCACHE = 3'h0,
    SRC_ICACHE = 3'h1,
    SRC_CCU_TAG = 3'h2,
    SRC_ITCR = 3'h3,
    SRC_DTCR = 3'h4
  } reh_src_t;
  localparam int NUM_BANKS = 5;
  localparam int LOC_W = 16;
  localparam int CNT_W = 16;
  // bank depths per source, in the order of reh_src_t
  localparam int DEPTH_CACHE = 3;
  localparam int DEPTH_CCU = 2;
  localparam int DEPTH_TCR = 1;
  localparam int MAX_DEPTH = 3;
  localparam int OCC_W = 2;
  // error-check enable field of the auxiliary control register
  localparam int AUX_ECC_LO = 9;
  localparam int AUX_ECC_HI = 10;
  // data word widths of the coded chunks
  localparam int DC_WORD_W = 32;
  localparam int DC_CODE_W = 7;
  localparam int IC_WORD_W = 64;
  localparam int IC_CODE_W = 8;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CLEAN_INV = 3'h1,
    ST_WRITEBACK = 3'h2,
    ST_RETRY = 3'h3
  } reh_state_t;
endpackage

// [src/reh_error_handler.sv]
// level-one ram error handler: classifies ram check results, runs
// the correct/clean/retry sequence, keeps error banks and reports events.
// assumes the ram arrays compute syndromes and perform clean, invalidate
// and writeback on request, acknowledging each with a done pulse.
//
// Contract
// - rams use sec-ded codes; handler corrects single and detects double errors
// - branch prediction rams carry parity only, no correction
// - array layout interleaves chunks so adjacent cells hit different words
// - correctable cache error: clean/invalidate index and way, then requester retries
// - correctable local ram error: correct, write back, then retry
// - instruction cache error: invalidate alone, refetch from next level
// - data cache: corrected contents pass into eviction during clean/invalidate
// - coherency tag error cleans matching core line, then marks duplicate unusable
// - error location pushed to bank while it has a free entry; bank masks valid on lookup and allocate
// - bank entry stays until software clears it via coprocessor operation
// - outputs show each bank's usage: empty, holding entries or full
// - coherency tag error also logged in the core's data bank
// - each error pulses an event output and bumps statistic counters; coherency tag errors pulse no event, branch prediction parity errors bump no counter
// - multi-bit error reports may come after the faulty access
// - bank depths: three per cache, two coherency tag, one per local ram
// - correctable errors notified only when both aux check bits set
// - dcache coded per 32-bit word, icache per 64; multi-bit fatal in dcache only dirty, in local rams always
`timescale 1ns/1ps
module reh_error_handler
  import reh_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire logic [AUX_ECC_HI:AUX_ECC_LO] auxiliary_control_reg_ecc,
  // error report from the arrays (syndrome already evaluated)
  input wire logic err_valid,
  input wire logic [2:0] err_src,
  input wire logic [LOC_W-1:0] err_loc,
  input wire logic err_single,
  input wire logic err_multi,
  input wire logic err_dirty,
  input wire logic [IC_WORD_W-1:0] err_rdata,
  input wire logic [IC_WORD_W-1:0] err_syndrome_mask,
  // parity report from branch prediction arrays
  input wire logic bp_parity_err,
  // maintenance handshake with arrays
  output logic clean_inv_req,
  output logic inval_only,
  output logic wb_req,
  output logic [LOC_W-1:0] maint_loc_ff,
  output logic [2:0] maint_src_ff,
  output logic [IC_WORD_W-1:0] corr_data_ff,
  input wire logic maint_done,
  // requester control
  output logic req_stall,
  output logic retry_pulse_ff,
  // lookup / allocate masking
  input wire logic [2:0] lookup_src,
  input wire logic [LOC_W-1:0] lookup_loc,
  output logic lookup_masked,
  input wire logic [2:0] alloc_src,
  input wire logic [LOC_W-1:0] alloc_loc,
  output logic alloc_masked,
  // software bank clear
  input wire logic sys_coproc_clr,
  input wire logic [2:0] sys_coproc_bank,
  input wire logic [1:0] sys_coproc_entry,
  // reporting
  output logic [NUM_BANKS-1:0] bank_nonempty_ff,
  output logic [NUM_BANKS-1:0] bank_full_ff,
  output logic ev_correctable_ff,
  output logic ev_fatal_ff,
  output logic ev_bp_parity_ff,
  output logic [CNT_W-1:0] cnt_correctable_ff,
  output logic [CNT_W-1:0] cnt_fatal_ff
);

  function automatic int bank_depth(input int b);
    if (b <= 1) begin
      return DEPTH_CACHE;
    end else if (b == 2) begin
      return DEPTH_CCU;
    end else begin
      return DEPTH_TCR;
    end
  endfunction

  logic [LOC_W-1:0] bank_loc_ff [NUM_BANKS][MAX_DEPTH];
  logic [MAX_DEPTH-1:0] bank_vld_ff [NUM_BANKS];
  reh_state_t state_ff;
  reh_state_t nxt_state;
  logic notify_corr;
  logic fatal;
  logic accept;

  // corrected/fatal classification; corrected needs both check bits
  // a non-fatal multi-bit error (clean line, icache) is still a corrected one
  assign notify_corr = (err_single || err_multi) && (&auxiliary_control_reg_ecc);
  // icache never dirty, so multi-bit there is corrected by refetch
  assign fatal = err_multi && ((err_src == SRC_DCACHE) ? err_dirty
                 : (err_src != SRC_ICACHE) && (err_src != SRC_CCU_TAG));
  assign accept = err_valid && (state_ff == ST_IDLE);

  function automatic logic hit(input logic [2:0] s, input logic [LOC_W-1:0] l,
                               input logic [LOC_W-1:0] locs [NUM_BANKS][MAX_DEPTH],
                               input logic [MAX_DEPTH-1:0] v [NUM_BANKS]);
    logic r;
    r = 1'b0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      for (int e = 0; e < MAX_DEPTH; e++) begin
        if (b == int'(s) && v[b][e] && locs[b][e] == l) begin
          r = 1'b1;
        end
      end
    end
    return r;
  endfunction

  // banked locations force valid low on lookup and allocation
  assign lookup_masked = hit(lookup_src, lookup_loc, bank_loc_ff, bank_vld_ff);
  assign alloc_masked = hit(alloc_src, alloc_loc, bank_loc_ff, bank_vld_ff);

  // one bank per ram with its own depth
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic push;
    int slot;
    // coherency tag errors land in the core's data bank too
    assign push = accept && (err_src == 3'(b) ||
                  (b == int'(SRC_DCACHE) && err_src == SRC_CCU_TAG));
    always_comb begin
      slot = MAX_DEPTH;
      for (int e = MAX_DEPTH - 1; e >= 0; e--) begin
        if (e < bank_depth(b) && !bank_vld_ff[b][e]) begin
          slot = e;
        end
      end
    end
    for (genvar e = 0; e < MAX_DEPTH; e++) begin : g_ent
      always_ff @(posedge clk) begin
        if (reset) begin
          bank_vld_ff[b][e] <= 1'b0;
          bank_loc_ff[b][e] <= '0;
        end else if (e < bank_depth(b)) begin
          // push wins over a same-cycle clear of the chosen slot
          if (push && slot == e) begin
            bank_vld_ff[b][e] <= 1'b1;
            bank_loc_ff[b][e] <= err_loc;
          end else if (sys_coproc_clr && sys_coproc_bank == 3'(b) &&
                       sys_coproc_entry == 2'(e)) begin
            bank_vld_ff[b][e] <= 1'b0;
          end
        end
      end
    end
    // usage pins let the system act before the bank fills
    always_ff @(posedge clk) begin
      if (reset) begin
        bank_nonempty_ff[b] <= 1'b0;
        bank_full_ff[b] <= 1'b0;
      end else begin
        bank_nonempty_ff[b] <= |bank_vld_ff[b];
        bank_full_ff[b] <= &(bank_vld_ff[b] | ~((MAX_DEPTH)'((1 << bank_depth(b)) - 1)));
      end
    end
  end

  // sequence: clean/invalidate for caches, writeback for correctable local ram errors, then retry
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          if (err_src == SRC_ITCR || err_src == SRC_DTCR) begin
            nxt_state = fatal ? ST_RETRY : ST_WRITEBACK;
          end else begin
            nxt_state = ST_CLEAN_INV;
          end
        end
      end
      ST_CLEAN_INV: begin
        if (maint_done) begin
          nxt_state = ST_RETRY;
        end
      end
      ST_WRITEBACK: begin
        if (maint_done) begin
          nxt_state = ST_RETRY;
        end
      end
      ST_RETRY: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // interleaved chunks turn a multi-cell upset into one flip per word
  // capture the faulty word and flip the bits the syndrome points at
  always_ff @(posedge clk) begin
    if (reset) begin
      maint_loc_ff <= '0;
      maint_src_ff <= 3'h0;
      corr_data_ff <= '0;
    end else if (accept) begin
      maint_loc_ff <= err_loc;
      maint_src_ff <= err_src;
      if (err_src == SRC_DCACHE || err_src == SRC_DTCR) begin
        corr_data_ff <= {{(IC_WORD_W-DC_WORD_W){1'b0}},
                         err_rdata[DC_WORD_W-1:0] ^ err_syndrome_mask[DC_WORD_W-1:0]};
      end else begin
        corr_data_ff <= err_rdata ^ err_syndrome_mask;
      end
    end
  end

  assign clean_inv_req = (state_ff == ST_CLEAN_INV);
  // icache lines are never dirty: plain invalidate is enough
  assign inval_only = clean_inv_req && (maint_src_ff == SRC_ICACHE);
  assign wb_req = (state_ff == ST_WRITEBACK);
  // stall covers the accept cycle so no access slips past the fix
  assign req_stall = accept || (state_ff != ST_IDLE);

  always_ff @(posedge clk) begin
    if (reset) begin
      retry_pulse_ff <= 1'b0;
    end else begin
      retry_pulse_ff <= (state_ff == ST_RETRY);
    end
  end

  // events may trail the access; no containment is implied
  always_ff @(posedge clk) begin
    if (reset) begin
      ev_correctable_ff <= 1'b0;
      ev_fatal_ff <= 1'b0;
      ev_bp_parity_ff <= 1'b0;
    end else begin
      ev_correctable_ff <= accept && !fatal && notify_corr && (err_src != SRC_CCU_TAG);
      ev_fatal_ff <= accept && fatal;
      ev_bp_parity_ff <= bp_parity_err;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_correctable_ff <= CNT_RESET;
      cnt_fatal_ff <= CNT_RESET;
    end else begin
      if (accept && !fatal) begin
        cnt_correctable_ff <= cnt_correctable_ff + 1'b1;
      end
      if (accept && fatal) begin
        cnt_fatal_ff <= cnt_fatal_ff + 1'b1;
      end
    end
  end

  property p_stall_hold;
    @(posedge clk) disable iff (reset) accept |-> req_stall ##1 req_stall;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall dropped");

  sequence s_ci_done;
    clean_inv_req && maint_done;
  endsequence
  property p_ci_retry;
    @(posedge clk) disable iff (reset) s_ci_done |-> ##2 retry_pulse_ff;
  endproperty
  a_ci_retry: assert property (p_ci_retry) else $error("no retry after clean");

  property p_tcr_wb;
    @(posedge clk) disable iff (reset)
      accept && !fatal && (err_src == SRC_DTCR) |=> wb_req;
  endproperty
  a_tcr_wb: assert property (p_tcr_wb) else $error("no writeback");

  property p_ic_inval;
    @(posedge clk) disable iff (reset) accept && err_src == SRC_ICACHE |=> inval_only;
  endproperty
  a_ic_inval: assert property (p_ic_inval) else $error("icache not invalidated");

  property p_push_mask;
    @(posedge clk) disable iff (reset)
      accept && err_src == SRC_DCACHE && !(&bank_vld_ff[0]) && !sys_coproc_clr
      |=> (|bank_vld_ff[0]) ##1 bank_nonempty_ff[0];
  endproperty
  a_push_mask: assert property (p_push_mask) else $error("bank not filled");

  property p_ccu_dbank;
    @(posedge clk) disable iff (reset)
      accept && err_src == SRC_CCU_TAG && !sys_coproc_clr ##1 1'b1 |=> bank_nonempty_ff[0];
  endproperty
  a_ccu_dbank: assert property (p_ccu_dbank) else $error("ccu not in dbank");

  property p_corr_gate;
    @(posedge clk) disable iff (reset)
      ev_correctable_ff |-> $past(&auxiliary_control_reg_ecc);
  endproperty
  a_corr_gate: assert property (p_corr_gate) else $error("ungated notify");

  property p_fatal_ev;
    @(posedge clk) disable iff (reset)
      accept && fatal |=> ev_fatal_ff && cnt_fatal_ff == $past(cnt_fatal_ff) + 1'b1;
  endproperty
  a_fatal_ev: assert property (p_fatal_ev) else $error("fatal not reported");

  property p_tcr_depth;
    @(posedge clk) disable iff (reset)
      !bank_vld_ff[2][2] && !bank_vld_ff[3][1] && !bank_vld_ff[3][2] &&
      !bank_vld_ff[4][1] && !bank_vld_ff[4][2];
  endproperty
  a_tcr_depth: assert property (p_tcr_depth) else $error("depth exceeded");
endmodule

// [tb/reh_array_model.sv]
// behavioural cache and local ram arrays answering maintenance requests
// assumes requests stay high until maint_done is seen at a clock edge
// no self-test port traffic: cores are never parked in wait_for_interrupt_state
`timescale 1ns/1ps
module reh_array_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // answer latency in cycles, set by the bench
  input wire logic [3:0] delay,
  // maintenance handshake
  input wire logic clean_inv_req,
  input wire logic wb_req,
  output logic maint_done
);
  logic [3:0] wait_ff;

  // one done pulse per request; clean, invalidate or writeback ends here
  always_ff @(posedge clk) begin
    if (reset || !(clean_inv_req || wb_req) || maint_done) begin
      wait_ff <= 4'h0;
      maint_done <= 1'b0;
    end else if (wait_ff >= delay) begin
      maint_done <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the level-one ram error handler
// assumes the array model answers maintenance; inputs move at falling edges
`timescale 1ns/1ps
module tb_top;
  import reh_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [AUX_ECC_HI:AUX_ECC_LO] auxiliary_control_reg_ecc = 2'h3;
  logic err_valid = 1'b0, err_single = 1'b0, err_multi = 1'b0, err_dirty = 1'b0;
  logic [2:0] err_src = 3'h0, lookup_src = 3'h0, alloc_src = 3'h0, sys_coproc_bank = 3'h0;
  logic [LOC_W-1:0] err_loc = 16'h0000, lookup_loc = 16'h0000, alloc_loc = 16'h0000;
  logic [IC_WORD_W-1:0] err_rdata = 64'h0, err_syndrome_mask = 64'h0;
  logic bp_parity_err = 1'b0, sys_coproc_clr = 1'b0;
  logic [1:0] sys_coproc_entry = 2'h0;
  logic [3:0] delay = 4'h0;
  logic clean_inv_req, inval_only, wb_req, maint_done, req_stall, retry_pulse_ff;
  logic lookup_masked, alloc_masked, ev_correctable_ff, ev_fatal_ff, ev_bp_parity_ff;
  logic [LOC_W-1:0] maint_loc_ff;
  logic [2:0] maint_src_ff;
  logic [IC_WORD_W-1:0] corr_data_ff;
  logic [NUM_BANKS-1:0] bank_nonempty_ff, bank_full_ff;
  logic [CNT_W-1:0] cnt_correctable_ff, cnt_fatal_ff;
  int err_count = 0;
  int samples_checked = 0;
  int n_corr = 0, n_fatal = 0, n_bp = 0;

  always #2.5 clk = ~clk;

  reh_error_handler uut (
    .clk(clk), .reset(reset), .auxiliary_control_reg_ecc(auxiliary_control_reg_ecc),
    .err_valid(err_valid), .err_src(err_src), .err_loc(err_loc),
    .err_single(err_single), .err_multi(err_multi), .err_dirty(err_dirty),
    .err_rdata(err_rdata), .err_syndrome_mask(err_syndrome_mask),
    .bp_parity_err(bp_parity_err),
    .clean_inv_req(clean_inv_req), .inval_only(inval_only), .wb_req(wb_req),
    .maint_loc_ff(maint_loc_ff), .maint_src_ff(maint_src_ff), .corr_data_ff(corr_data_ff),
    .maint_done(maint_done), .req_stall(req_stall), .retry_pulse_ff(retry_pulse_ff),
    .lookup_src(lookup_src), .lookup_loc(lookup_loc), .lookup_masked(lookup_masked),
    .alloc_src(alloc_src), .alloc_loc(alloc_loc), .alloc_masked(alloc_masked),
    .sys_coproc_clr(sys_coproc_clr), .sys_coproc_bank(sys_coproc_bank),
    .sys_coproc_entry(sys_coproc_entry),
    .bank_nonempty_ff(bank_nonempty_ff), .bank_full_ff(bank_full_ff),
    .ev_correctable_ff(ev_correctable_ff), .ev_fatal_ff(ev_fatal_ff),
    .ev_bp_parity_ff(ev_bp_parity_ff),
    .cnt_correctable_ff(cnt_correctable_ff), .cnt_fatal_ff(cnt_fatal_ff)
  );
  reh_array_model arrays (.clk(clk), .reset(reset), .delay(delay),
    .clean_inv_req(clean_inv_req), .wb_req(wb_req), .maint_done(maint_done));

  // event outputs last one cycle, so tally them as they pass
  always @(posedge clk) begin
    if (ev_correctable_ff === 1'b1) n_corr <= n_corr + 1;
    if (ev_fatal_ff === 1'b1) n_fatal <= n_fatal + 1;
    if (ev_bp_parity_ff === 1'b1) n_bp <= n_bp + 1;
  end

  task chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task run_err(input logic [2:0] src, input logic sgl, input logic mlt, input logic [15:0] loc,
               input logic [63:0] rd, input logic [63:0] msk, input logic ci, input logic wb);
    int i;
    @(negedge clk);
    err_valid = 1'b1;
    err_src = src;
    err_single = sgl;
    err_multi = mlt;
    err_loc = loc;
    err_rdata = rd;
    err_syndrome_mask = msk;
    @(negedge clk);
    err_valid = 1'b0;
    chk(clean_inv_req === ci && wb_req === wb, "wrong maintenance request");
    chk(!(ci || wb) || maint_loc_ff === loc, "wrong maintenance location");
    chk(maint_src_ff === src, "wrong maintenance source");
    chk(!ci || inval_only === (src == 3'h1), "wrong invalidate kind");
    for (i = 0; i < 40 && retry_pulse_ff !== 1'b1; i++) begin
      chk(req_stall === 1'b1, "requester not stalled");
      @(negedge clk);
    end
    chk(retry_pulse_ff === 1'b1, "no retry pulse");
    if (retry_pulse_ff !== 1'b1) begin
      final_report();
    end
  endtask

  task look(input logic [2:0] src, input logic [15:0] loc, input logic exp, input string msg);
    @(negedge clk);
    lookup_src = src;
    lookup_loc = loc;
    alloc_src = src;
    alloc_loc = loc;
    #1;
    chk(lookup_masked === exp && alloc_masked === exp, msg);
  endtask

  task s_cache_fix;
    delay = 4'h5;
    run_err(3'h0, 1'b1, 1'b0, 16'h0012, 64'h0, 64'h0, 1'b1, 1'b0);
    chk(n_corr === 1 && cnt_correctable_ff === 16'h0001, "correctable report");
    chk(bank_nonempty_ff === 5'h01, "bank usage");
    look(3'h0, 16'h0012, 1'b1, "faulty line usable");
    look(3'h0, 16'h0013, 1'b0, "healthy line masked");
  endtask

  task s_icache_quiet;
    @(negedge clk);
    auxiliary_control_reg_ecc = 2'h0;
    delay = 4'h0;
    run_err(3'h1, 1'b1, 1'b0, 16'h0020, 64'h0, 64'h0, 1'b1, 1'b0);
    chk(n_corr === 1 && cnt_correctable_ff === 16'h0002, "notified while disabled");
    auxiliary_control_reg_ecc = 2'h3;
  endtask

  task s_local_ram;
    run_err(3'h4, 1'b1, 1'b0, 16'h0040, 64'hFFFF_FFFF_1234_5678,
            64'h0000_0000_0000_0100, 1'b0, 1'b1);
    chk(corr_data_ff[31:0] === 32'h1234_5778, "corrected word");
    chk(bank_full_ff[4] === 1'b1, "one-entry bank not full");
    run_err(3'h4, 1'b0, 1'b1, 16'h0041, 64'h0, 64'h3, 1'b0, 1'b0);
    chk(n_fatal === 1 && cnt_fatal_ff === 16'h0001, "fatal report");
    look(3'h4, 16'h0041, 1'b0, "push into full bank kept");
  endtask

  task s_ccu_tag;
    run_err(3'h2, 1'b1, 1'b0, 16'h0077, 64'h0, 64'h0, 1'b1, 1'b0);
    chk(bank_nonempty_ff[2] === 1'b1, "tag bank empty");
    look(3'h0, 16'h0077, 1'b1, "tag error not in data bank");
  endtask

  task s_full_clear;
    run_err(3'h0, 1'b1, 1'b0, 16'h0099, 64'h0, 64'h0, 1'b1, 1'b0);
    chk(bank_full_ff[0] === 1'b1, "three-entry bank not full");
    @(negedge clk);
    // the monitor frees an entry only once it has proved the error soft
    sys_coproc_clr = 1'b1;
    sys_coproc_bank = 3'h0;
    sys_coproc_entry = 2'h0;
    @(negedge clk);
    sys_coproc_clr = 1'b0;
    @(negedge clk);
    look(3'h0, 16'h0012, 1'b0, "cleared entry still masks");
    look(3'h0, 16'h0099, 1'b1, "other entry lost");
    chk(bank_full_ff[0] === 1'b0, "bank still full");
  endtask

  task s_multi_bit;
    run_err(3'h1, 1'b0, 1'b1, 16'h0021, 64'h0, 64'h0, 1'b1, 1'b0);
    chk(n_fatal === 1 && n_corr === 4, "icache multi-bit not corrected");
    err_dirty = 1'b1;
    run_err(3'h0, 1'b0, 1'b1, 16'h0031, 64'h0, 64'h0, 1'b1, 1'b0);
    err_dirty = 1'b0;
    chk(n_fatal === 2 && cnt_fatal_ff === 16'h0002, "dirty multi-bit not fatal");
    chk(bank_full_ff[0] === 1'b1, "refilled bank not full");
  endtask

  task s_parity;
    @(negedge clk);
    bp_parity_err = 1'b1;
    @(negedge clk);
    bp_parity_err = 1'b0;
    repeat (2) @(negedge clk);
    chk(n_bp === 1 && req_stall === 1'b0, "parity report");
  endtask

  task final_report;
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clk);
    reset = 1'b0;
    s_cache_fix();
    s_icache_quiet();
    s_local_ram();
    s_ccu_tag();
    s_full_clear();
    s_multi_bit();
    s_parity();
    final_report();
  end
endmodule
